// >>> debounce_consts.vh
// constants for the contact input debouncer: register map, fields, timing
// assumes a 100 MHz system clock and a 32-bit AHB-Lite register port
`ifndef DEBOUNCE_CONSTS_VH
`define DEBOUNCE_CONSTS_VH

`define CLK_PERIOD_NS      8'h0a
`define SCAN_PERIOD_US     16'h01f4
`define SCAN_PERIOD_NS     (500 * 1000)
`define SCAN_CYCLES        (`SCAN_PERIOD_NS / 10)
`define TS_UNIT_NS         1000
`define TS_CYCLES          (`TS_UNIT_NS / 10)
`define DEB_SAMPLES_RST    8'h05

`define OFF_CTRL           8'h00
`define OFF_DEB_TIME       8'h04
`define OFF_EVT_EN         8'h08
`define OFF_THRESH         8'h0c
`define OFF_RAW            8'h10
`define OFF_STATE          8'h14
`define OFF_STATUS         8'h18
`define OFF_MASK           8'h1c
`define OFF_TS_SEL         8'h20
`define OFF_TS_VAL         8'h24
`define OFF_TIME_NOW       8'h28

`define CTRL_SCAN_EN_BIT   0
`endif

// >>> debounce_channel.v
// one contact input channel: threshold compare, symmetric debounce, stamp
// assumes scan_tick is a one-cycle pulse every scan period
`timescale 1ns/10ps
module debounce_channel #(
  parameter LEVEL_W = 8,
  parameter CNT_W   = 8,
  parameter TS_W    = 32
) (
  input  wire               clk,
  input  wire               rst_b,
  input  wire               scan_tick,
  input  wire [LEVEL_W-1:0] level,
  input  wire [LEVEL_W-1:0] threshold,
  input  wire [CNT_W-1:0]   samples_needed,
  input  wire [TS_W-1:0]    time_now,
  output reg                state,
  output reg                validated,
  output reg  [TS_W-1:0]    stamp
);
  reg              cand_reg;
  reg [CNT_W-1:0]  run_reg;
  reg [TS_W-1:0]   first_ts_reg;
  wire             raw;

  assign raw = (level >= threshold);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state        <= 1'b0;
      validated    <= 1'b0;
      stamp        <= {TS_W{1'b0}};
      cand_reg     <= 1'b0;
      run_reg      <= {CNT_W{1'b0}};
      first_ts_reg <= {TS_W{1'b0}};
    end
    else
    begin
      validated <= 1'b0;
      if (scan_tick)
      begin
        if (raw == state)
        begin
          run_reg <= {CNT_W{1'b0}};
          cand_reg <= state;
        end
        else if (raw != cand_reg || run_reg == {CNT_W{1'b0}})
        begin
          // new candidate: first sample of a run, stamp it
          cand_reg     <= raw;
          first_ts_reg <= time_now;
          run_reg      <= {{(CNT_W-1){1'b0}}, 1'b1};
          if (samples_needed <= {{(CNT_W-1){1'b0}}, 1'b1})
          begin
            state     <= raw;
            validated <= 1'b1;
            stamp     <= time_now;
            run_reg   <= {CNT_W{1'b0}};
          end
        end
        else if (run_reg + 1'b1 >= samples_needed)
        begin
          state     <= raw;
          validated <= 1'b1;
          stamp     <= first_ts_reg;
          run_reg   <= {CNT_W{1'b0}};
        end
        else
        begin
          run_reg <= run_reg + 1'b1;
        end
      end
    end
  end
endmodule

// >>> contact_input_debouncer.v
// contact input debouncer top: scan timer, channels, pass-aligned state, AHB-Lite regs
// assumes a single 100 MHz clock, synchronous inputs, one AHB-Lite master
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`include "debounce_consts.vh"
module contact_input_debouncer #(
  parameter N_GROUPS = 2,
  parameter LEVEL_W  = 8,
  parameter TS_W     = 32,
  parameter SCAN_CYC = `SCAN_CYCLES
) (
  input  wire                          CLK,
  input  wire                          RST_B,
  input  wire [N_GROUPS*4*LEVEL_W-1:0] LEVEL,
  input  wire                          PASS_START,
  input  wire                          HSEL,
  input  wire [31:0]                   HADDR,
  input  wire [1:0]                    HTRANS,
  input  wire                          HWRITE,
  input  wire [2:0]                    HSIZE,
  input  wire [31:0]                   HWDATA,
  input  wire                          HREADY,
  output reg  [31:0]                   HRDATA,
  output wire                          HREADYOUT,
  output wire                          HRESP,
  output wire [N_GROUPS*4-1:0]         INPUT_CLOSED_FLAG,
  output wire [N_GROUPS*4-1:0]         INPUT_OPEN_FLAG,
  output reg  [N_GROUPS*4-1:0]         EVENT_PULSE,
  output reg  [TS_W*N_GROUPS*4-1:0]    EVENT_STAMP,
  output wire                          IRQ
);
  localparam N = N_GROUPS * 4;

  function [N-1:0] low_n;
    input [31:0] w;
    begin
      low_n = w[N-1:0];
    end
  endfunction

  reg        rst_s1_reg;
  reg        rst_s2_reg;
  wire       rst_b;

  always @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_b = rst_s2_reg;

  // software state
  reg                      scan_en_reg;
  reg  [7:0]               deb_samples_reg;
  reg  [N-1:0]             evt_en_reg;
  reg  [LEVEL_W*N_GROUPS-1:0] thresh_reg;
  reg  [N-1:0]             status_reg;
  reg  [N-1:0]             mask_reg;
  reg  [7:0]               ts_sel_reg;

  // scan and microsecond timers
  reg  [31:0]              scan_cnt_reg;
  reg  [7:0]               us_cnt_reg;
  reg  [TS_W-1:0]          time_now_reg;
  wire                     scan_tick;

  always @(posedge CLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_cnt_reg <= 32'h0;
      us_cnt_reg   <= 8'h0;
      time_now_reg <= {TS_W{1'b0}};
    end
    else
    begin
      if (scan_cnt_reg == SCAN_CYC - 1)
        scan_cnt_reg <= 32'h0;
      else
        scan_cnt_reg <= scan_cnt_reg + 32'h1;
      if (us_cnt_reg == `TS_CYCLES - 1)
      begin
        us_cnt_reg   <= 8'h0;
        time_now_reg <= time_now_reg + 1'b1;
      end
      else
        us_cnt_reg <= us_cnt_reg + 8'h1;
    end
  end
  assign scan_tick = scan_en_reg && (scan_cnt_reg == SCAN_CYC - 1);

  // channels
  wire [N-1:0]        deb_state;
  wire [N-1:0]        deb_valid;
  wire [TS_W*N-1:0]   deb_stamp;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : ch
      debounce_channel #(
        .LEVEL_W (LEVEL_W),
        .CNT_W   (8),
        .TS_W    (TS_W)
      ) u_ch (
        .clk            (CLK),
        .rst_b          (rst_b),
        .scan_tick      (scan_tick),
        .level          (LEVEL[g*LEVEL_W +: LEVEL_W]),
        .threshold      (thresh_reg[(g/4)*LEVEL_W +: LEVEL_W]),
        .samples_needed (deb_samples_reg),
        .time_now       (time_now_reg),
        .state          (deb_state[g]),
        .validated      (deb_valid[g]),
        .stamp          (deb_stamp[g*TS_W +: TS_W])
      );
    end
  endgenerate

  // pass-aligned presented state; pass strobe comes from frequency tracking
  reg  [N-1:0] presented_reg;
  always @(posedge CLK or negedge rst_b)
  begin
    if (!rst_b)
      presented_reg <= {N{1'b0}};
    else if (PASS_START)
      presented_reg <= deb_state;
  end
  assign INPUT_CLOSED_FLAG = presented_reg;
  assign INPUT_OPEN_FLAG   = ~presented_reg;

  // event output, both directions, gated per input
  integer i;
  always @(posedge CLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      EVENT_PULSE <= {N{1'b0}};
      EVENT_STAMP <= {(TS_W*N){1'b0}};
    end
    else
    begin
      EVENT_PULSE <= deb_valid & evt_en_reg;
      for (i = 0; i < N; i = i + 1)
        if (deb_valid[i] && evt_en_reg[i])
          EVENT_STAMP[i*TS_W +: TS_W] <= deb_stamp[i*TS_W +: TS_W];
    end
  end

  // AHB-Lite slave, zero wait states
  reg         dp_wr_reg;
  reg  [7:0]  dp_addr_reg;
  wire        ap_valid;

  assign ap_valid  = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  always @(posedge CLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h0;
    end
    else if (HREADY)
    begin
      dp_wr_reg   <= ap_valid && HWRITE;
      dp_addr_reg <= HADDR[7:0];
    end
  end

  wire [N-1:0] w1c = (dp_wr_reg && dp_addr_reg == `OFF_STATUS) ? low_n(HWDATA) : {N{1'b0}};
  wire [N-1:0] set_evt = deb_valid & evt_en_reg;

  always @(posedge CLK or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scan_en_reg     <= 1'b1;
      deb_samples_reg <= `DEB_SAMPLES_RST;
      evt_en_reg      <= {N{1'b0}};
      thresh_reg      <= {(LEVEL_W*N_GROUPS){1'b0}};
      status_reg      <= {N{1'b0}};
      mask_reg        <= {N{1'b0}};
      ts_sel_reg      <= 8'h0;
    end
    else
    begin
      // set wins over write-one-clear
      status_reg <= (status_reg & ~w1c) | set_evt;
      if (dp_wr_reg)
      begin
        case (dp_addr_reg)
          `OFF_CTRL:     scan_en_reg     <= HWDATA[`CTRL_SCAN_EN_BIT];
          `OFF_DEB_TIME: deb_samples_reg <= HWDATA[7:0];
          `OFF_EVT_EN:   evt_en_reg      <= low_n(HWDATA);
          `OFF_THRESH:   thresh_reg      <= HWDATA[LEVEL_W*N_GROUPS-1:0];
          `OFF_MASK:     mask_reg        <= low_n(HWDATA);
          `OFF_TS_SEL:   ts_sel_reg      <= HWDATA[7:0];
          default:       ;
        endcase
      end
    end
  end

  assign IRQ = |(status_reg & mask_reg);

  reg [N-1:0] raw_now;
  integer k;
  always @*
  begin
    for (k = 0; k < N; k = k + 1)
      raw_now[k] = (LEVEL[k*LEVEL_W +: LEVEL_W] >= thresh_reg[(k/4)*LEVEL_W +: LEVEL_W]);
  end

  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0;
    case (HADDR[7:0])
      `OFF_CTRL:     rd_mux[0]   = scan_en_reg;
      `OFF_DEB_TIME: rd_mux[7:0] = deb_samples_reg;
      `OFF_EVT_EN:   rd_mux[N-1:0] = evt_en_reg;
      `OFF_THRESH:   rd_mux[LEVEL_W*N_GROUPS-1:0] = thresh_reg;
      `OFF_RAW:      rd_mux[N-1:0] = raw_now;
      `OFF_STATE:    rd_mux[N-1:0] = deb_state;
      `OFF_STATUS:   rd_mux[N-1:0] = status_reg;
      `OFF_MASK:     rd_mux[N-1:0] = mask_reg;
      `OFF_TS_SEL:   rd_mux[7:0] = ts_sel_reg;
      `OFF_TS_VAL:
      begin
        if (ts_sel_reg < N)
          rd_mux[TS_W-1:0] = EVENT_STAMP[ts_sel_reg*TS_W +: TS_W];
      end
      `OFF_TIME_NOW: rd_mux[TS_W-1:0] = time_now_reg;
      default:       rd_mux = 32'h0;
    endcase
  end

  always @(posedge CLK or negedge rst_b)
  begin
    if (!rst_b)
      HRDATA <= 32'h0;
    // loaded at the address phase so it stands through the data phase;
    // a read right after a write to the same register sees the old value
    else if (ap_valid && !HWRITE)
      HRDATA <= rd_mux;
  end
endmodule

// >>> cid_asserts.sv
// assertions on the contact input debouncer top ports
// assumes a bind into the top; one clock, RST_B active low
`timescale 1ns/10ps
module cid_asserts #(
  parameter N_GROUPS = 2
) (
  input wire logic                  CLK,
  input wire logic                  RST_B,
  input wire logic                  PASS_START,
  input wire logic                  HSEL,
  input wire logic [1:0]            HTRANS,
  input wire logic                  HWRITE,
  input wire logic                  HREADY,
  input wire logic                  HREADYOUT,
  input wire logic                  HRESP,
  input wire logic [N_GROUPS*4-1:0] INPUT_CLOSED_FLAG,
  input wire logic [N_GROUPS*4-1:0] INPUT_OPEN_FLAG,
  input wire logic [N_GROUPS*4-1:0] EVENT_PULSE,
  input wire logic                  IRQ
);
  wire wr = HSEL & HREADY & HTRANS[1] & HWRITE;
  wire ev = |EVENT_PULSE;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // after an event, no further event for the next eight cycles
  sequence s_quiet;
    !ev [*8];
  endsequence
  // register write whose data phase ended one edge ago
  sequence s_wr_done;
    $past(wr, 2);
  endsequence
  a_open_compl: assert property (INPUT_OPEN_FLAG == ~INPUT_CLOSED_FLAG)
    else $error("open flags not complement");
  a_flag_at_pass: assert property (!$stable(INPUT_CLOSED_FLAG) |-> $past(PASS_START))
    else $error("closed flags moved without pass start");
  a_flag_hold: assert property (!PASS_START |=> $stable(INPUT_CLOSED_FLAG))
    else $error("closed flags not held between passes");
  a_pulse_gap: assert property (ev |=> s_quiet)
    else $error("event pulse too long or too close");
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  a_reset_clear: assert property (disable iff (1'b0) !RST_B |=> !INPUT_CLOSED_FLAG && !ev && !IRQ)
    else $error("outputs not cleared by reset");
  a_irq_rise: assert property ($rose(IRQ) |-> ev || $past(ev) || $past(wr, 2))
    else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(IRQ) |-> s_wr_done)
    else $error("irq fell without a write");
endmodule

// >>> wet_contacts.sv
// wet contact model: sensed levels for eight inputs from a closed map
// assumes the bench gives one threshold byte per group of four
`timescale 1ns/10ps
module wet_contacts (
  input  wire [7:0]  closed,
  input  wire        clk,
  input  wire [15:0] thr,
  output reg  [63:0] level = 64'h0
);
  integer k;
  reg [7:0] t;
  // noisy level: closed never below the threshold, open never at it
  always @(posedge clk)
  begin
    for (k = 0; k < 8; k = k + 1)
    begin
      t = thr[(k/4)*8+:8];
      level[k*8+:8] <= closed[k] ? t + 8'($urandom % 4) : t - 8'h1 - 8'($urandom % 4);
    end
  end
endmodule

// >>> contact_input_debouncer_tb_top.sv
// bench for the contact input debouncer: bus tasks, contact model, checks
// assumes 100 MHz and a scan period shortened to 200 cycles
`timescale 1ns/10ps
`include "debounce_consts.vh"
module contact_input_debouncer_tb_top;
  localparam P = 200;
  logic         CLK = 0;
  logic         RST_B = 0;
  logic         PASS_START = 0;
  logic         HSEL = 0;
  logic [31:0]  HADDR = 0;
  logic [1:0]   HTRANS = 0;
  logic         HWRITE = 0;
  logic [31:0]  HWDATA = 0;
  logic [31:0]  HRDATA;
  logic         HREADYOUT;
  logic         HRESP;
  logic [7:0]   INPUT_CLOSED_FLAG;
  logic [7:0]   INPUT_OPEN_FLAG;
  logic [7:0]   EVENT_PULSE;
  logic [255:0] EVENT_STAMP;
  logic         IRQ;
  logic [63:0]  LEVEL;
  logic [7:0]   cl = 0;
  logic [15:0]  pthr = 16'h5028;
  logic [31:0]  got;
  logic [7:0]   pcnt = 0;
  logic [7:0]   evq[$];
  logic [31:0]  rdq[$];
  int           cyc = 0;
  int           bad_count = 0;
  int           checked = 0;
  event         rd_ev;
  contact_input_debouncer #(.SCAN_CYC(P)) contact_input_debouncer_i (
    .CLK(CLK), .RST_B(RST_B), .LEVEL(LEVEL), .PASS_START(PASS_START), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .INPUT_CLOSED_FLAG(INPUT_CLOSED_FLAG), .INPUT_OPEN_FLAG(INPUT_OPEN_FLAG),
    .EVENT_PULSE(EVENT_PULSE), .EVENT_STAMP(EVENT_STAMP), .IRQ(IRQ));
  wet_contacts wet_contacts_i (.clk(CLK), .closed(cl), .thr(pthr), .level(LEVEL));
  always #5 CLK = ~CLK;
  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input [7:0] a, input w, input [31:0] d, output [31:0] q);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    bus(a, 1'b1, d, got);
  endtask
  task automatic rd(input [7:0] a, input [31:0] e);
    rdq.push_back(e);
    bus(a, 1'b0, 32'h0, got);
    ->rd_ev;
  endtask
  task automatic irq_is(input bit e);
    repeat (2) @(posedge CLK);
    chk(IRQ === e, "irq level");
  endtask
  // change the contacts, optionally with one bounce back, then follow through
  task automatic step(input [7:0] nc, input bit bn, input [7:0] ev, input [7:0] ef);
    int t;
    int k;
    logic [31:0] now;
    logic [7:0] old;
    old = cl;
    cl <= nc;
    t = cyc;
    if (bn)
    begin
      repeat (3 * P) @(posedge CLK);
      cl <= old;
      repeat (P) @(posedge CLK);
      cl <= nc;
      t = cyc;
    end
    if (ev != 0)
      evq.push_back(ev);
    while (EVENT_PULSE === 8'h0 && cyc - t < 7 * P)
      @(posedge CLK);
    if (ev != 0)
    begin
      chk(cyc - t > 5 * P && cyc - t <= 6 * P + 8, "validation delay");
      k = 0;
      while (!ev[k])
        k++;
      bus(`OFF_TIME_NOW, 1'b0, 32'h0, now);
      chk(now - EVENT_STAMP[k*32+:32] inside {10, 11}, "stamp");
    end
    while (PASS_START !== 1'b1)
      @(posedge CLK);
    #1 chk(INPUT_CLOSED_FLAG === ef && INPUT_OPEN_FLAG === ~ef, "closed flags");
    @(posedge CLK);
  endtask
  task automatic rstep;
    logic [7:0] n;
    n = 8'($urandom);
    step(n, n[0], (n ^ cl) & 8'h7f, n);
  endtask
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    // pass period wanders as frequency tracking would move it
    pcnt <= (pcnt == 0) ? 8'd150 + 8'($urandom % 100) : pcnt - 8'h1;
    PASS_START <= (pcnt == 0);
    if (EVENT_PULSE !== 8'h0)
      chk(evq.size() > 0 && EVENT_PULSE === evq.pop_front(), "event vector");
    if (cyc == 60000)
    begin
      bad_count++;
      complete_run;
    end
  end
  always @(rd_ev)
    chk(got === rdq.pop_front(), "read data");
  initial
  begin
    void'($urandom(1));
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CLK);
    wr(`OFF_THRESH, 32'h7828);
    rd(`OFF_CTRL, 32'h1);
    wr(`OFF_CTRL, 32'h0);
    rd(`OFF_CTRL, 32'h0);
    wr(`OFF_CTRL, 32'h1);
    wr(`OFF_TS_SEL, 32'h3);
    rd(`OFF_TS_SEL, 32'h3);
    rd(`OFF_DEB_TIME, 32'h5);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    wr(`OFF_DEB_TIME, 32'h6);
    wr(`OFF_EVT_EN, 32'hff);
    wr(`OFF_MASK, 32'hff);
    step(8'h05, 1'b0, 8'h05, 8'h05);
    irq_is(1'b1);
    rd(`OFF_STATUS, 32'h5);
    rd(`OFF_STATE, 32'h5);
    rd(`OFF_RAW, 32'h5);
    wr(`OFF_STATUS, 32'h5);
    irq_is(1'b0);
    wr(`OFF_MASK, 32'h0);
    step(8'h0f, 1'b1, 8'h0a, 8'h0f);
    irq_is(1'b0);
    wr(`OFF_MASK, 32'hff);
    irq_is(1'b1);
    step(8'hfc, 1'b0, 8'h03, 8'h0c);
    wr(`OFF_STATUS, 32'hff);
    wr(`OFF_EVT_EN, 32'h7f);
    pthr <= 16'h2828;
    cl <= 8'h0c;
    wr(`OFF_THRESH, 32'h2828);
    step(8'hcc, 1'b0, 8'h40, 8'hcc);
    repeat (4) rstep();
    cl <= 8'h0;
    RST_B <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_B <= 1'b1;
    #1 chk(INPUT_CLOSED_FLAG === 8'h0, "flags after reset");
    repeat (3) @(posedge CLK);
    rd(`OFF_DEB_TIME, 32'h5);
    complete_run;
  end
endmodule
bind contact_input_debouncer cid_asserts #(.N_GROUPS(N_GROUPS)) cid_asserts_i (
  .CLK(CLK), .RST_B(RST_B), .PASS_START(PASS_START), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .INPUT_CLOSED_FLAG(INPUT_CLOSED_FLAG), .INPUT_OPEN_FLAG(INPUT_OPEN_FLAG),
  .EVENT_PULSE(EVENT_PULSE), .IRQ(IRQ));
